//--- logic/bqw_pkg.sv
package bqw_pkg;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned AM_W         = 6;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned SYNC_STAGES  = 2;
  // default window of the on-board resource
  localparam logic [31:0] BASE_RESET   = 32'h0010_0000;
  localparam logic [31:0] MASK_RESET   = 32'hfff0_0000;
  localparam logic [5:0]  AM_RESET     = 6'h09;
  // cycles from strobes seen to write issue, kept small
  localparam int unsigned STORE_CYCLES = 1;
endpackage : bqw_pkg

//--- logic/bqw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bqw_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // level in, level out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule : bqw_sync
`default_nettype wire

//--- logic/bqw_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - on AS low, slave decodes address, modifier, LWORD, IACK; selects if in range
// - WRITE low and both strobes low: slave captures all 32 data lines
// - after storing the word, slave drives DTACK low
// - slave releases DTACK only after DS0, DS1 high and either AS high or a pipelined AS pending
// - slave works correctly with pipelined cycles
// - slave latches address and qualifiers on falling edge of AS
// - new AS must not disturb address still needed by earlier cycle
module bqw_slave
  import bqw_pkg::*;
(
  // clock and reset
  input  wire logic                       MCLK,
  input  wire logic                       RESET,
  // address phase
  input  wire logic [bqw_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [bqw_pkg::AM_W-1:0]   AM,
  input  wire logic                       LWORD_N,
  input  wire logic                       IACK_N,
  input  wire logic                       AS_N,
  // data phase
  input  wire logic                       WRITE_N,
  input  wire logic                       DS0_N,
  input  wire logic                       DS1_N,
  input  wire logic [bqw_pkg::DATA_W-1:0] DATA_IN,
  // acknowledge, open drain: low enable drives low
  output var  logic                       DTACK_O,
  output var  logic                       DTACK_OE_N,
  // selection window
  input  wire logic [bqw_pkg::ADDR_W-1:0] SEL_BASE,
  input  wire logic [bqw_pkg::ADDR_W-1:0] SEL_MASK,
  input  wire logic [bqw_pkg::AM_W-1:0]   SEL_AM,
  // on-board resource write port
  output var  logic                       WR_VALID,
  output var  logic [bqw_pkg::ADDR_W-1:0] WR_ADDR,
  output var  logic [bqw_pkg::AM_W-1:0]   WR_AM,
  output var  logic [bqw_pkg::DATA_W-1:0] WR_DATA,
  input  wire logic                       WR_READY,
  // status
  output var  logic                       BUSY
);
  import bqw_pkg::*;

  typedef enum logic [2:0] {
    BQW_IDLE, BQW_WAIT_DS, BQW_STORE, BQW_ACK, BQW_WAIT_REL
  } bqw_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [3:0] strb_sync;
  logic       as_s;
  logic       ds0_s;
  logic       ds1_s;
  logic       wr_s;

  bqw_sync #(.W(4)) u_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   ({AS_N, DS0_N, DS1_N, WRITE_N}),
    .q   (strb_sync)
  );

  assign {as_s, ds0_s, ds1_s, wr_s} = strb_sync;

  ////////////////////////////////////////////////////////////////////////////
  // address latch on falling AS

  logic                as_d_reg;
  logic                as_fall;
  logic [ADDR_W-1:0]   a_reg,   a_next;
  logic [AM_W-1:0]     am_reg,  am_next;
  logic                hit_reg, hit_next;
  logic                pend_reg, pend_next;
  logic                hit_now;

  assign as_fall = as_d_reg & ~as_s;

  // address lines are sampled one edge after AS is seen low; the master
  // holds them until a slave answers, which no slave does before that
  assign hit_now = ((ADDR & SEL_MASK) == (SEL_BASE & SEL_MASK))
                 && (AM == SEL_AM) && !LWORD_N && IACK_N;

  logic [ADDR_W-1:0] pa_reg, pa_next;
  logic [AM_W-1:0]   pam_reg, pam_next;
  logic              phit_reg, phit_next;

  bqw_state_t st_reg, st_next;

  always_comb begin
    a_next    = a_reg;
    am_next   = am_reg;
    hit_next  = hit_reg;
    pend_next = pend_reg;
    if (as_fall) begin
      // a pipelined address waits in the pending slot while the earlier
      // cycle still owns the latched copy
      if (st_reg == BQW_IDLE) begin
        a_next   = ADDR;
        am_next  = AM;
        hit_next = hit_now;
      end else begin
        pend_next = 1'b1;
      end
    end
    if (pend_reg && st_reg == BQW_IDLE) begin
      // a pending pipelined address is promoted on return to idle
      a_next    = pa_reg;
      am_next   = pam_reg;
      hit_next  = phit_reg;
      pend_next = 1'b0;
    end
  end

  always_comb begin
    pa_next   = pa_reg;
    pam_next  = pam_reg;
    phit_next = phit_reg;
    if (as_fall && st_reg != BQW_IDLE) begin
      pa_next   = ADDR;
      pam_next  = AM;
      phit_next = hit_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake

  logic [DATA_W-1:0] d_reg, d_next;
  logic              dtack_reg, dtack_next;
  logic              wv_reg, wv_next;

  always_comb begin
    st_next    = st_reg;
    d_next     = d_reg;
    dtack_next = dtack_reg;
    wv_next    = wv_reg;
    unique case (st_reg)
      BQW_IDLE: begin
        if (as_fall || pend_reg) begin
          st_next = BQW_WAIT_DS;
        end
      end
      BQW_WAIT_DS: begin
        if (as_s) begin
          st_next = BQW_IDLE;
        end else if (!hit_reg) begin
          // not ours: drop when AS rises
          st_next = BQW_WAIT_DS;
        end else if (!wr_s && !ds0_s && !ds1_s) begin
          d_next  = DATA_IN;
          wv_next = 1'b1;
          st_next = BQW_STORE;
        end
      end
      BQW_STORE: begin
        if (WR_READY) begin
          wv_next    = 1'b0;
          dtack_next = 1'b1;
          st_next    = BQW_ACK;
        end
      end
      BQW_ACK: begin
        if (ds0_s && ds1_s) begin
          st_next = BQW_WAIT_REL;
        end
      end
      BQW_WAIT_REL: begin
        // AS may already be low again for the next cycle
        if (ds0_s && ds1_s && (as_s || pend_reg)) begin
          dtack_next = 1'b0;
          st_next    = BQW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_reg    <= BQW_IDLE;
      as_d_reg  <= 1'b1;
      a_reg     <= '0;
      am_reg    <= '0;
      hit_reg   <= 1'b0;
      pend_reg  <= 1'b0;
      pa_reg    <= '0;
      pam_reg   <= '0;
      phit_reg  <= 1'b0;
      d_reg     <= '0;
      dtack_reg <= 1'b0;
      wv_reg    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      as_d_reg  <= as_s;
      a_reg     <= a_next;
      am_reg    <= am_next;
      hit_reg   <= hit_next;
      pend_reg  <= pend_next;
      pa_reg    <= pa_next;
      pam_reg   <= pam_next;
      phit_reg  <= phit_next;
      d_reg     <= d_next;
      dtack_reg <= dtack_next;
      wv_reg    <= wv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign DTACK_O    = 1'b0;
  assign DTACK_OE_N = ~dtack_reg;
  assign WR_VALID   = wv_reg;
  assign WR_ADDR    = a_reg;
  assign WR_AM      = am_reg;
  assign WR_DATA    = d_reg;
  assign BUSY       = (st_reg != BQW_IDLE);
endmodule : bqw_slave
`default_nettype wire

//--- testbench/bqw_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bqw_slave_checker (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic [31:0] ADDR,
  input wire logic        AS_N,
  input wire logic        WRITE_N,
  input wire logic        DS0_N,
  input wire logic        DS1_N,
  input wire logic [31:0] DATA_IN,
  input wire logic        DTACK_OE_N,
  input wire logic [31:0] SEL_BASE,
  input wire logic [31:0] SEL_MASK,
  input wire logic        WR_VALID,
  input wire logic        WR_READY,
  input wire logic [31:0] WR_ADDR,
  input wire logic [31:0] WR_DATA
);
  logic        as_prev_reg;
  logic [31:0] fall_addr_reg;
  // address as it stood when the strobe fell, the only copy a pipelined master guarantees
  always_ff @(posedge MCLK) begin
    as_prev_reg <= AS_N;
    if (as_prev_reg && !AS_N) fall_addr_reg <= ADDR;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_dtack_after_store: assert property ($fell(DTACK_OE_N) |-> $past(WR_VALID && WR_READY))
    else $error("dtack before store");
  a_dtack_release: assert property ($rose(DTACK_OE_N) |-> $past(DS0_N && DS1_N, 3))
    else $error("dtack released early");
  a_dtack_bound: assert property ((AS_N && DS0_N && DS1_N) [*6] |-> DTACK_OE_N)
    else $error("dtack stuck low");
  a_store_hold: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_DATA))
    else $error("store dropped");
  a_store_cause: assert property ($rose(WR_VALID) |-> $past(!DS0_N && !DS1_N && !WRITE_N, 3))
    else $error("store without strobes");
  a_store_data: assert property ($rose(WR_VALID) |-> WR_DATA == $past(DATA_IN))
    else $error("store data wrong");
  a_store_window: assert property ($rose(WR_VALID) |-> (WR_ADDR & SEL_MASK) == (SEL_BASE & SEL_MASK))
    else $error("store outside window");
  a_addr_latched: assert property ($rose(WR_VALID) |-> WR_ADDR == fall_addr_reg)
    else $error("address not latched");
endmodule : bqw_slave_checker
bind bqw_slave bqw_slave_checker u_chk (
  .MCLK       (MCLK),
  .RESET      (RESET),
  .ADDR       (ADDR),
  .AS_N       (AS_N),
  .WRITE_N    (WRITE_N),
  .DS0_N      (DS0_N),
  .DS1_N      (DS1_N),
  .DATA_IN    (DATA_IN),
  .DTACK_OE_N (DTACK_OE_N),
  .SEL_BASE   (SEL_BASE),
  .SEL_MASK   (SEL_MASK),
  .WR_VALID   (WR_VALID),
  .WR_READY   (WR_READY),
  .WR_ADDR    (WR_ADDR),
  .WR_DATA    (WR_DATA)
);
`default_nettype wire

//--- testbench/bqw_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bqw_master_model (
  input  wire logic        MCLK,
  input  wire logic        DTACK_N,
  output var  logic [31:0] ADDR,
  output var  logic [5:0]  AM,
  output var  logic        LWORD_N,
  output var  logic        IACK_N,
  output var  logic        AS_N,
  output var  logic        WRITE_N,
  output var  logic        DS0_N,
  output var  logic        DS1_N,
  output var  logic [31:0] DATA
);
  initial begin
    {AS_N, DS0_N, DS1_N, WRITE_N, LWORD_N, IACK_N} = '1;
    {ADDR, AM, DATA} = '0;
  end
  // bounded, so a silent slave cannot hang the master
  task automatic hold(input logic lvl);
    for (int n = 0; n < 20 && DTACK_N !== lvl; n++) @(negedge MCLK);
  endtask : hold
  // pipe: na is broadcast as the next address; a strobe already low means it is on the bus
  task automatic write(input logic [31:0] a, input logic [5:0] m, input logic [31:0] d,
                       input bit pipe, input logic [31:0] na, output bit acked);
    if (AS_N) begin
      @(negedge MCLK);
      {ADDR, AM, LWORD_N, IACK_N} = {a, m, 2'b01};
      @(negedge MCLK);
      AS_N = 1'b0;
    end
    WRITE_N = 1'b0;
    hold(1'b1);
    DATA = d;
    @(negedge MCLK);
    {DS0_N, DS1_N} = 2'b00;
    hold(1'b0);
    acked = !DTACK_N;
    DATA = ~d;
    if (pipe) begin
      // next strobe overlaps the old data strobes, so the slave must queue it
      {ADDR, AS_N} = {na, 1'b1};
      @(negedge MCLK);
      AS_N = 1'b0;
      @(negedge MCLK);
      {DS0_N, DS1_N} = 2'b11;
    end else begin
      // released lines show the inverse, not a stale copy
      {ADDR, AM, LWORD_N} = {~a, ~m, 1'b1};
      {DS0_N, DS1_N} = 2'b11;
      @(negedge MCLK);
      {AS_N, WRITE_N} = 2'b11;
      hold(1'b1);
    end
  endtask : write
endmodule : bqw_master_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bqw_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        ready = 1'b0;
  logic        seen = 1'b0;
  logic        lword_n, iack_n, as_n, write_n, ds0_n, ds1_n, dtack_o, dtack_oe_n, wr_valid, busy;
  logic [31:0] addr, data, wr_addr, wr_data, got_addr, got_data;
  logic [5:0]  am, wr_am;
  wire  logic  dtack_n = dtack_oe_n ? 1'b1 : dtack_o;
  int          err_count = 0;
  int          samples_checked = 0;
  int          stores = 0;
  initial forever #50 mclk = ~mclk;
  // resource answers one cycle late so the store request must wait
  always @(negedge mclk) begin
    seen <= wr_valid;
    ready <= wr_valid & ~ready & seen;
  end
  always @(posedge mclk) if (wr_valid && ready) begin
    stores++;
    {got_addr, got_data} = {wr_addr, wr_data};
  end
  bqw_slave DUT (.MCLK(mclk), .RESET(reset), .ADDR(addr), .AM(am), .LWORD_N(lword_n),
    .IACK_N(iack_n), .AS_N(as_n), .WRITE_N(write_n), .DS0_N(ds0_n), .DS1_N(ds1_n),
    .DATA_IN(data), .DTACK_O(dtack_o), .DTACK_OE_N(dtack_oe_n), .SEL_BASE(BASE_RESET),
    .SEL_MASK(MASK_RESET), .SEL_AM(AM_RESET), .WR_VALID(wr_valid), .WR_ADDR(wr_addr),
    .WR_AM(wr_am), .WR_DATA(wr_data), .WR_READY(ready), .BUSY(busy));
  bqw_master_model mst (.MCLK(mclk), .DTACK_N(dtack_n), .ADDR(addr), .AM(am),
    .LWORD_N(lword_n), .IACK_N(iack_n), .AS_N(as_n), .WRITE_N(write_n), .DS0_N(ds0_n),
    .DS1_N(ds1_n), .DATA(data));
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic t_single();
    bit ack;
    mst.write(32'h0010_0a5c, AM_RESET, 32'hc3a5_0f96, 1'b0, 32'h0000_0000, ack);
    chk(ack && stores == 1, "single ack");
    chk(got_addr === 32'h0010_0a5c && got_data === 32'hc3a5_0f96, "single word");
    chk(wr_am === AM_RESET && dtack_n === 1'b1, "single end");
    chk(busy === 1'b0, "single busy");
  endtask : t_single
  task automatic t_miss();
    bit a1, a2;
    mst.write(32'h0020_0000, AM_RESET, 32'h0000_0001, 1'b0, 32'h0000_0000, a1);
    mst.write(32'h0010_0000, 6'h3d, 32'h0000_0002, 1'b0, 32'h0000_0000, a2);
    chk(!a1 && !a2 && stores == 1, "miss answered");
    chk(busy === 1'b1, "miss busy until strobe seen high");
  endtask : t_miss
  task automatic t_pipe();
    bit a1, a2;
    mst.write(32'h001f_fffc, AM_RESET, 32'h5a5a_a5a5, 1'b1, 32'h0010_0004, a1);
    chk(a1 && got_addr === 32'h001f_fffc && got_data === 32'h5a5a_a5a5, "pipe one");
    mst.write(32'h0010_0004, AM_RESET, 32'h0123_4567, 1'b0, 32'h0000_0000, a2);
    chk(a2 && got_addr === 32'h0010_0004 && got_data === 32'h0123_4567, "pipe two");
    chk(stores == 3 && busy === 1'b0, "pipe count");
  endtask : t_pipe
  task automatic close_out();
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    t_single();
    t_miss();
    t_pipe();
    close_out();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
